// ### rpvb_pkg.sv
// Constants, types and carriers shared by the receive pattern verifier
// register block. Assumes byte-wide registers on the control port.
`default_nettype none
package rpvb_pkg;

  // ******************************************************************
  // Register offsets
  // ******************************************************************
  localparam logic [7:0] CUSTOM_PATTERN_MID_OFS   = 8'h12;
  localparam logic [7:0] CUSTOM_PATTERN_TOP_OFS   = 8'h13;
  localparam logic [7:0] RETAIN_THRESHOLD_OFS     = 8'h14;
  localparam logic [7:0] DESKEW_CLEAR_SOURCE_OFS  = 8'h15;
  localparam logic [7:0] DATAPATH_CHECK_CTRL_OFS  = 8'h16;
  localparam logic [7:0] LANE_TEST_FLAGS_OFS      = 8'h17;
  localparam logic [7:0] LANE0_COUNT_LOW_OFS      = 8'h18;
  localparam logic [7:0] LANE0_COUNT_HIGH_OFS     = 8'h19;
  localparam logic [7:0] LANE1_COUNT_LOW_OFS      = 8'h1A;
  localparam logic [7:0] LANE1_COUNT_HIGH_OFS     = 8'h1B;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int ALIGN_DONE_BIT    = 7;
  localparam int COUNTER_CLEAR_BIT = 4;
  localparam int FLAG_CLEAR_BIT    = 3;
  localparam int SOURCE_SEL_LSB    = 0;
  localparam int CHECK_ENABLE_LSB  = 4;
  localparam int ERROR_TYPE_LSB    = 0;
  localparam int LATCHED_FLAG_LSB  = 4;
  localparam int RAW_FLAG_LSB      = 0;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [7:0] REG_RESET_VALUE  = 8'h00;
  localparam logic [2:0] SEL_RESET_VALUE  = 3'h0;
  localparam logic [3:0] NIBBLE_RESET     = 4'h0;

  // ******************************************************************
  // Sizes
  // ******************************************************************
  localparam int LANES       = 4;
  localparam int COUNT_WIDTH = 12;

  // Datapath error type codes; 5 to 7 are reserved
  typedef enum logic [2:0] {
    RPVB_DP_DISPARITY = 3'h0,
    RPVB_DP_BUFFER    = 3'h1,
    RPVB_DP_OVERFLOW  = 3'h2,
    RPVB_DP_UNDERFLOW = 3'h3,
    RPVB_DP_DESKEW    = 3'h4
  } rpvb_dp_type_t;

  // Per-lane event sources from the receive lanes
  typedef struct packed {
    logic [3:0] pattern_mismatch;
    logic [3:0] disparity;
    logic [3:0] buffer_err;
    logic [3:0] overflow;
    logic [3:0] underflow;
  } rpvb_lane_events_t;

  // Byte register request from the control port decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpvb_reg_req_t;

endpackage
`default_nettype wire

// ### rpvb_sat_counter.sv
// Saturating event counter with synchronous clear.
// Assumes the event is a one-cycle-per-error strobe on MCLK.
`timescale 1ns/1ps
`default_nettype none
module rpvb_sat_counter #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic             clear_i,
  input  wire logic             event_i,
  // Count
  output logic [WIDTH-1:0]      count_o
);

  logic [WIDTH-1:0] count_q;  // Running count
  logic             at_max;   // Counter is full

  assign at_max  = &count_q;
  assign count_o = count_q;

  // ******************************************************************
  // Count, clear and saturate
  // ******************************************************************
  // An error in the clearing cycle is kept so none is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else if (clear_i) begin
      count_q <= {{(WIDTH-1){1'b0}}, event_i};
    end else if (event_i && !at_max) begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

// ### rpvb_regs.sv
// Receive pattern verifier and error counter registers, 0x12 to 0x1B.
// Assumes the control port decoder hands byte requests on MCLK and that
// all lane event inputs are already synchronous to MCLK.
`timescale 1ns/1ps
`default_nettype none
module rpvb_regs #(
  parameter int NUM_LANES = rpvb_pkg::LANES,
  parameter int CNT_WIDTH = rpvb_pkg::COUNT_WIDTH
) (
  // Clock and reset
  input  wire logic                       MCLK_I,
  input  wire logic                       RST_I,
  // Register port from the control port decoder
  input  wire rpvb_pkg::rpvb_reg_req_t    REG_REQ_I,
  output logic [7:0]                      REG_RDATA_O,
  // Neighbouring pattern controls
  input  wire logic                       CUSTOM_LENGTH_TWENTY_I,
  input  wire logic [7:0]                 CUSTOM_PATTERN_LOW_I,
  // Lane status and events
  input  wire logic                       LANE_ALIGN_DONE_I,
  input  wire rpvb_pkg::rpvb_lane_events_t LANE_EVENTS_I,
  // Controls to the receive lanes
  output logic [19:0]                     CUSTOM_PATTERN_O,
  output logic [2:0]                      RETAIN_THRESHOLD_O,
  output logic [NUM_LANES-1:0]            LATCHED_TEST_FLAG_O
);
  import rpvb_pkg::*;

  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic [7:0]           pattern_mid_q;      // Custom pattern 15:8
  logic [3:0]           pattern_top_q;      // Custom pattern 19:16
  logic [2:0]           retain_threshold_q; // Verifier retain threshold
  logic                 counter_clear_q;    // Self-clearing clear bit
  logic                 counter_clear_d;
  logic                 counter_clear_p_q;  // Previous clear bit
  logic                 flag_clear_q;       // Self-clearing flag clear
  logic                 flag_clear_d;
  logic [2:0]           source_sel_q;       // Test interrupt source
  logic [3:0]           check_enable_q;     // Per-lane datapath enable
  logic [2:0]           error_type_q;       // Datapath error type
  logic [3:0]           raw_flag_q;         // Raw test flags
  logic [3:0]           raw_flag_d;
  logic [3:0]           latched_flag_q;     // Latched test flags
  logic [3:0]           latched_flag_d;
  logic [7:0]           rdata_q;            // Read data register
  logic [7:0]           rdata_d;
  logic                 counter_clear_pulse;
  logic                 dp_active;          // Any datapath enable set
  logic                 dp_event;           // Selected datapath error
  logic [3:0]           src_event;          // Per-lane selected source
  logic [CNT_WIDTH-1:0] lane0_count;
  logic [CNT_WIDTH-1:0] lane1_count;
  logic                 wr_hit_mid;
  logic                 wr_hit_top;
  logic                 wr_hit_thr;
  logic                 wr_hit_ctl;
  logic                 wr_hit_dp;

  // ******************************************************************
  // Write decode
  // ******************************************************************
  // Offsets not listed here take no write at all
  assign wr_hit_mid = REG_REQ_I.wr && REG_REQ_I.addr == CUSTOM_PATTERN_MID_OFS;
  assign wr_hit_top = REG_REQ_I.wr && REG_REQ_I.addr == CUSTOM_PATTERN_TOP_OFS;
  assign wr_hit_thr = REG_REQ_I.wr && REG_REQ_I.addr == RETAIN_THRESHOLD_OFS;
  assign wr_hit_ctl = REG_REQ_I.wr
                      && REG_REQ_I.addr == DESKEW_CLEAR_SOURCE_OFS;
  assign wr_hit_dp  = REG_REQ_I.wr
                      && REG_REQ_I.addr == DATAPATH_CHECK_CTRL_OFS;

  // ******************************************************************
  // Custom pattern and threshold registers
  // ******************************************************************
  // Middle pattern byte, fully writable
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      pattern_mid_q <= REG_RESET_VALUE;
    end else if (wr_hit_mid) begin
      pattern_mid_q <= REG_REQ_I.wdata;
    end
  end

  // Top nibble only; upper bits are reserved and dropped
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      pattern_top_q <= NIBBLE_RESET;
    end else if (wr_hit_top) begin
      pattern_top_q <= REG_REQ_I.wdata[3:0];
    end
  end

  // Retain threshold, three bits
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      retain_threshold_q <= SEL_RESET_VALUE;
    end else if (wr_hit_thr) begin
      retain_threshold_q <= REG_REQ_I.wdata[2:0];
    end
  end

  // Sixteen-bit mode forces the top nibble out as zero so a stale
  // value cannot leak into the comparator
  always_comb begin
    if (CUSTOM_LENGTH_TWENTY_I) begin
      CUSTOM_PATTERN_O = {pattern_top_q, pattern_mid_q,
                          CUSTOM_PATTERN_LOW_I};
    end else begin
      CUSTOM_PATTERN_O = {NIBBLE_RESET, pattern_mid_q,
                          CUSTOM_PATTERN_LOW_I};
    end
  end

  assign RETAIN_THRESHOLD_O = retain_threshold_q;

  // ******************************************************************
  // Clear strobes and source select
  // ******************************************************************
  // Each strobe stands one cycle after the write, then drops by itself
  always_comb begin
    counter_clear_d = 1'b0;
    flag_clear_d    = 1'b0;
    if (wr_hit_ctl) begin
      counter_clear_d = REG_REQ_I.wdata[COUNTER_CLEAR_BIT];
      flag_clear_d    = REG_REQ_I.wdata[FLAG_CLEAR_BIT];
    end
  end

  // Self-clearing control bits
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      counter_clear_q   <= 1'b0;
      counter_clear_p_q <= 1'b0;
      flag_clear_q      <= 1'b0;
    end else begin
      counter_clear_q   <= counter_clear_d;
      counter_clear_p_q <= counter_clear_q;
      flag_clear_q      <= flag_clear_d;
    end
  end

  // Only a rising edge clears; a repeated write while high does not
  assign counter_clear_pulse = counter_clear_q
                               & ~counter_clear_p_q;

  // Test interrupt source select
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      source_sel_q <= SEL_RESET_VALUE;
    end else if (wr_hit_ctl) begin
      source_sel_q <= REG_REQ_I.wdata[SOURCE_SEL_LSB +: 3];
    end
  end

  // ******************************************************************
  // Datapath check control
  // ******************************************************************
  // Bit 3 is reserved and never stored
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      check_enable_q <= NIBBLE_RESET;
      error_type_q   <= SEL_RESET_VALUE;
    end else if (wr_hit_dp) begin
      check_enable_q <= REG_REQ_I.wdata[CHECK_ENABLE_LSB +: 4];
      error_type_q   <= REG_REQ_I.wdata[ERROR_TYPE_LSB +: 3];
    end
  end

  assign dp_active = |check_enable_q;

  // Selected datapath error, gathered from the enabled lanes; deskew uses the alignment status instead
  always_comb begin
    unique case (error_type_q)
      RPVB_DP_DISPARITY: begin
        dp_event = |(LANE_EVENTS_I.disparity & check_enable_q);
      end
      RPVB_DP_BUFFER: begin
        dp_event = |(LANE_EVENTS_I.buffer_err & check_enable_q);
      end
      RPVB_DP_OVERFLOW: begin
        dp_event = |(LANE_EVENTS_I.overflow & check_enable_q);
      end
      RPVB_DP_UNDERFLOW: begin
        dp_event = |(LANE_EVENTS_I.underflow & check_enable_q);
      end
      RPVB_DP_DESKEW: begin
        // Reported while alignment has not completed
        dp_event = ~LANE_ALIGN_DONE_I;
      end
      default: begin
        // Reserved codes report nothing
        dp_event = 1'b0;
      end
    endcase
  end

  // Per-lane test source, chosen by the source select field
  always_comb begin
    unique case (source_sel_q)
      3'h0:    src_event = LANE_EVENTS_I.pattern_mismatch;
      3'h1:    src_event = LANE_EVENTS_I.disparity;
      3'h2:    src_event = LANE_EVENTS_I.buffer_err;
      3'h3:    src_event = LANE_EVENTS_I.overflow;
      3'h4:    src_event = LANE_EVENTS_I.underflow;
      default: src_event = NIBBLE_RESET;
    endcase
  end

  // ******************************************************************
  // Raw and latched test flags
  // ******************************************************************
  // Lane 0 is taken over by the datapath check when it is enabled
  always_comb begin
    raw_flag_d = src_event;
    if (dp_active) begin
      raw_flag_d[0] = dp_event;
    end
  end

  // Raw flags follow the events, one cycle late
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      raw_flag_q <= NIBBLE_RESET;
    end else begin
      raw_flag_q <= raw_flag_d;
    end
  end

  // A new event wins over a clear in the same cycle
  assign latched_flag_d = (latched_flag_q & {4{~flag_clear_q}})
                          | raw_flag_d;

  // Sticky flags
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      latched_flag_q <= NIBBLE_RESET;
    end else begin
      latched_flag_q <= latched_flag_d;
    end
  end

  assign LATCHED_TEST_FLAG_O = latched_flag_q;

  // ******************************************************************
  // Error counters for lanes 0 and 1
  // ******************************************************************
  // Lanes 2 and 3 have their own counters elsewhere
  rpvb_sat_counter #(
    .WIDTH   (CNT_WIDTH)
  ) u_lane0_counter (
    .clk_i   (MCLK_I),
    .rst_i   (RST_I),
    .clear_i (counter_clear_pulse),
    .event_i (raw_flag_d[0]),
    .count_o (lane0_count)
  );

  rpvb_sat_counter #(
    .WIDTH   (CNT_WIDTH)
  ) u_lane1_counter (
    .clk_i   (MCLK_I),
    .rst_i   (RST_I),
    .clear_i (counter_clear_pulse),
    .event_i (raw_flag_d[1]),
    .count_o (lane1_count)
  );

  // ******************************************************************
  // Read mux
  // ******************************************************************
  // Reserved bits and foreign offsets read as zero
  always_comb begin
    rdata_d = REG_RESET_VALUE;
    unique case (REG_REQ_I.addr)
      CUSTOM_PATTERN_MID_OFS: begin
        rdata_d = pattern_mid_q;
      end
      CUSTOM_PATTERN_TOP_OFS: begin
        rdata_d[3:0] = pattern_top_q;
      end
      RETAIN_THRESHOLD_OFS: begin
        rdata_d[2:0] = retain_threshold_q;
      end
      DESKEW_CLEAR_SOURCE_OFS: begin
        rdata_d[ALIGN_DONE_BIT]    = LANE_ALIGN_DONE_I;
        rdata_d[COUNTER_CLEAR_BIT] = counter_clear_q;
        rdata_d[FLAG_CLEAR_BIT]    = flag_clear_q;
        rdata_d[SOURCE_SEL_LSB +: 3] = source_sel_q;
      end
      DATAPATH_CHECK_CTRL_OFS: begin
        rdata_d[CHECK_ENABLE_LSB +: 4] = check_enable_q;
        rdata_d[ERROR_TYPE_LSB +: 3]   = error_type_q;
      end
      LANE_TEST_FLAGS_OFS: begin
        rdata_d[LATCHED_FLAG_LSB +: 4] = latched_flag_q;
        rdata_d[RAW_FLAG_LSB +: 4]     = raw_flag_q;
      end
      LANE0_COUNT_LOW_OFS: begin
        rdata_d = lane0_count[7:0];
      end
      LANE0_COUNT_HIGH_OFS: begin
        rdata_d[3:0] = lane0_count[11:8];
      end
      LANE1_COUNT_LOW_OFS: begin
        rdata_d = lane1_count[7:0];
      end
      LANE1_COUNT_HIGH_OFS: begin
        rdata_d[3:0] = lane1_count[11:8];
      end
      default: begin
        rdata_d = REG_RESET_VALUE;
      end
    endcase
  end

  // Read data is captured on the read strobe and held afterwards
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rdata_q <= REG_RESET_VALUE;
    end else if (REG_REQ_I.rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA_O = rdata_q;

endmodule
`default_nettype wire

// ### rpvb_regs_chk.sv
// Port-level checker for the verifier register block.
// Assumes it is bound to the block by the bench; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module rpvb_regs_chk #(
  parameter int NUM_LANES = 4,
  parameter int CNT_WIDTH = 12
) (
  // Clock and reset
  input  wire logic                        MCLK_I,
  input  wire logic                        RST_I,
  // Register port
  input  wire rpvb_pkg::rpvb_reg_req_t     REG_REQ_I,
  input  wire logic [7:0]                  REG_RDATA_O,
  // Pattern and lane inputs
  input  wire logic                        CUSTOM_LENGTH_TWENTY_I,
  input  wire logic [7:0]                  CUSTOM_PATTERN_LOW_I,
  input  wire logic                        LANE_ALIGN_DONE_I,
  input  wire rpvb_pkg::rpvb_lane_events_t LANE_EVENTS_I,
  // Controls out
  input  wire logic [19:0]                 CUSTOM_PATTERN_O,
  input  wire logic [2:0]                  RETAIN_THRESHOLD_O,
  input  wire logic [NUM_LANES-1:0]        LATCHED_TEST_FLAG_O
);
  import rpvb_pkg::*;
  // ************
  // Helper decode
  // ************
  logic                 w12;    // Write to middle pattern byte
  logic                 w14;    // Write to threshold
  logic                 wclr;   // Write with flag-clear bit
  logic                 rd_any; // Any read
  logic [3:0]           any_ev; // Any event per lane
  logic [NUM_LANES-1:0] flag_q; // Flags one cycle back
  logic [3:0]           ev_q;   // Events one cycle back
  assign w12 = REG_REQ_I.wr && REG_REQ_I.addr == CUSTOM_PATTERN_MID_OFS;
  assign w14 = REG_REQ_I.wr && REG_REQ_I.addr == RETAIN_THRESHOLD_OFS;
  assign wclr = REG_REQ_I.wr && REG_REQ_I.wdata[FLAG_CLEAR_BIT]
             && REG_REQ_I.addr == DESKEW_CLEAR_SOURCE_OFS;
  assign rd_any = REG_REQ_I.rd;
  assign any_ev = LANE_EVENTS_I.pattern_mismatch | LANE_EVENTS_I.disparity
               | LANE_EVENTS_I.buffer_err | LANE_EVENTS_I.overflow
               | LANE_EVENTS_I.underflow;
  // Delayed copies; lane 0 skipped below since it has extra sources
  always_ff @(posedge MCLK_I) begin
    flag_q <= LATCHED_TEST_FLAG_O;
    ev_q   <= any_ev;
  end
  // ************
  // Assertions
  // ************
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  top_nibble_a: assert property (!CUSTOM_LENGTH_TWENTY_I |->
    CUSTOM_PATTERN_O[19:16] == 4'h0) else $error("top nibble leaked");
  low_byte_a: assert property (
    CUSTOM_PATTERN_O[7:0] == CUSTOM_PATTERN_LOW_I) else $error("low byte");
  mid_write_a: assert property (w12 |=>
    CUSTOM_PATTERN_O[15:8] == $past(REG_REQ_I.wdata))
    else $error("middle pattern byte not stored");
  thr_write_a: assert property (w14 |=>
    RETAIN_THRESHOLD_O == $past(REG_REQ_I.wdata[2:0]))
    else $error("threshold not stored");
  thr_keep_a: assert property (!w14 |=>
    $stable(RETAIN_THRESHOLD_O)) else $error("threshold moved");
  flag_drop_a: assert property (
    (|(flag_q & ~LATCHED_TEST_FLAG_O)) |-> $past(wclr, 2))
    else $error("latched flag dropped without clear");
  flag_cause_a: assert property (!(|(LATCHED_TEST_FLAG_O[3:1]
    & ~flag_q[3:1] & ~ev_q[3:1]))) else $error("flag set with no event");
  rdata_keep_a: assert property (!rd_any |=>
    $stable(REG_RDATA_O)) else $error("read data moved without read");
  unmapped_a: assert property (rd_any && (REG_REQ_I.addr < 8'h12
    || REG_REQ_I.addr > 8'h1B) |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  align_bit_a: assert property ($stable(LANE_ALIGN_DONE_I) [*3]
    ##0 (rd_any && REG_REQ_I.addr == DESKEW_CLEAR_SOURCE_OFS) |=>
    REG_RDATA_O[ALIGN_DONE_BIT] == $past(LANE_ALIGN_DONE_I))
    else $error("alignment bit wrong");
endmodule
`default_nettype wire

// ### rpvb_regs_test.sv
// Self-checking bench for the verifier register block.
// Assumes the package, the block and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rpvb_regs_test;
  import rpvb_pkg::*;
  // ************
  // Signals
  // ************
  logic              clk = 1'b0;  // 250 MHz clock
  logic              rst;         // Synchronous reset
  rpvb_reg_req_t     rq;          // Register request
  logic [7:0]        rdata;       // Read data
  logic              twenty;      // Twenty-bit pattern mode
  logic [7:0]        pat_low;     // Low pattern byte
  logic              align;       // Lanes aligned
  rpvb_lane_events_t events;      // Lane error strobes
  logic [19:0]       pattern;     // Assembled pattern
  logic [2:0]        thr;         // Retain threshold
  logic [3:0]        flags;       // Latched flags
  int                errors = 0;  // Mismatches
  int                n_checks = 0; // Comparisons
  int                cyc = 0;     // Cycle counter for the hang guard
  int                e;           // Expected count
  // Rows: address, write data, expected read back
  logic [23:0] rows [13] = '{24'h12A5A5, 24'h13FF0F, 24'h14FF07,
    24'h15E787, 24'h16FFF7, 24'h160000, 24'h17FF00, 24'h18FF00,
    24'h19FF00, 24'h1AFF00, 24'h1BFF00, 24'h20FF00, 24'h11FF00};
  always #2 clk = ~clk;
  rpvb_regs dut (
    .MCLK_I(clk), .RST_I(rst), .REG_REQ_I(rq), .REG_RDATA_O(rdata),
    .CUSTOM_LENGTH_TWENTY_I(twenty), .CUSTOM_PATTERN_LOW_I(pat_low),
    .LANE_ALIGN_DONE_I(align), .LANE_EVENTS_I(events),
    .CUSTOM_PATTERN_O(pattern), .RETAIN_THRESHOLD_O(thr),
    .LATCHED_TEST_FLAG_O(flags)
  );
  // ************
  // Tasks
  // ************
  task test_done();
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [19:0] x, input logic [19:0] g);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  // One request cycle; the next call or an idle call ends it
  task req(input logic w, input logic r, input logic [7:0] a, d);
    @(posedge clk);
    rq <= {w, r, a, d};
  endtask
  task wr(input logic [7:0] a, d);
    req(1'b1, 1'b0, a, d);
    req(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task rd(input logic [7:0] a, x);
    req(1'b0, 1'b1, a, 8'h00);
    req(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    chk($sformatf("reg %h", a), x, rdata);
  endtask
  // Strobe bit reads one for a cycle, then falls back on its own
  task strobe(input logic [7:0] d);
    req(1'b1, 1'b0, 8'h15, d);
    req(1'b0, 1'b1, 8'h15, 8'h00);
    req(1'b0, 1'b1, 8'h15, 8'h00);
    #1;
    chk("strobe set", d, rdata & d);
    req(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    chk("strobe self clear", 0, rdata & d);
  endtask
  // Field f strobed on lanes m for n cycles
  task ev(input logic [3:0] m, input int f, input int n);
    repeat (n) begin
      @(posedge clk);
      events <= 20'(m) << (4 * (4 - f));
    end
    @(posedge clk);
    events <= '0;
  endtask
  task zero_all();
    for (int a = 8'h12; a <= 8'h1B; a++)
      rd(8'(a), a == 8'h15 ? {align, 7'h00} : 8'h00);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      test_done();
    end
  end
  // ************
  // Main sequence
  // ************
  initial begin
    rst = 1'b1;
    rq = '0;
    twenty = 1'b0;
    pat_low = 8'h5A;
    align = 1'b0;
    events = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    zero_all();
    @(posedge clk);
    align <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk("pattern", 20'h0A55A, pattern);
    chk("threshold", 20'h7, thr);
    @(posedge clk);
    twenty <= 1'b1;
    @(posedge clk);
    #1;
    chk("pattern", 20'hFA55A, pattern);
    // Write and read together return the old value
    req(1'b1, 1'b1, 8'h12, 8'h3C);
    req(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    chk("same cycle read", 8'hA5, rdata);
    rd(8'h12, 8'h3C);
    // Every source code, with a wrong-source burst as noise
    for (int s = 0; s < 8; s++) begin
      wr(8'h15, 8'h18 | 8'(s));
      ev(4'h3, s % 5, 3);
      ev(4'h3, (s + 1) % 5, 2);
      e = s < 5 ? 3 : 0;
      rd(8'h18, 8'(e));
      rd(8'h1A, 8'(e));
      rd(8'h17, s < 5 ? 8'h30 : 8'h00);
    end
    // Raw flag seen in the cycle after its event
    wr(8'h15, 8'h18);
    @(posedge clk);
    events <= 20'h40000;
    req(1'b0, 1'b1, 8'h17, 8'h00);
    events <= '0;
    req(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    chk("raw flags", 8'h44, rdata);
    // Datapath types on lanes 1 and 2; lane 3 not enabled
    for (int t = 0; t < 8; t++) begin
      wr(8'h16, 8'h60 | 8'(t));
      wr(8'h15, 8'h1D);
      if (t < 4) begin
        ev(4'h6, t + 1, 2);
        ev(4'h8, t + 1, 1);
      end else if (t == 4) begin
        @(posedge clk);
        align <= 1'b0;
        repeat (4) @(posedge clk);
        align <= 1'b1;
      end else begin
        ev(4'h6, 1, 2);
      end
      e = t < 4 ? 2 : (t == 4 ? 4 : 0);
      rd(8'h18, 8'(e));
      chk("lane0 flag", e != 0, flags[0]);
    end
    wr(8'h16, 8'h00);
    // Saturation, then both clears
    wr(8'h15, 8'h18);
    ev(4'h2, 0, 4100);
    rd(8'h1A, 8'hFF);
    rd(8'h1B, 8'h0F);
    strobe(8'h10);
    rd(8'h1A, 8'h00);
    rd(8'h17, 8'h20);
    chk("latched flags", 20'h2, flags);
    strobe(8'h08);
    rd(8'h17, 8'h00);
    chk("latched flags", 20'h0, flags);
    // Reset in mid-run
    wr(8'h14, 8'h05);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    zero_all();
    chk("threshold", 0, thr);
    test_done();
  end
endmodule
bind rpvb_regs rpvb_regs_chk #(
  .NUM_LANES(NUM_LANES), .CNT_WIDTH(CNT_WIDTH)
) chk (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .REG_REQ_I(REG_REQ_I),
  .REG_RDATA_O(REG_RDATA_O), .CUSTOM_LENGTH_TWENTY_I(CUSTOM_LENGTH_TWENTY_I),
  .CUSTOM_PATTERN_LOW_I(CUSTOM_PATTERN_LOW_I),
  .LANE_ALIGN_DONE_I(LANE_ALIGN_DONE_I), .LANE_EVENTS_I(LANE_EVENTS_I),
  .CUSTOM_PATTERN_O(CUSTOM_PATTERN_O), .RETAIN_THRESHOLD_O(RETAIN_THRESHOLD_O),
  .LATCHED_TEST_FLAG_O(LATCHED_TEST_FLAG_O)
);
`default_nettype wire
